// ### core/flash_seq.sv
// buffer-to-page program, buffer load and block erase sequencer
// assumes link pins asynchronous to ref_clk, array reports verify failures
`timescale 1ns/1ps
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int page_program_cycles = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS,
  parameter int block_erase_cycles = BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // link pins
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // shared state with the rest of the device
  input wire logic write_enable_set,
  input wire logic protected_region,
  input wire logic residue_we,
  input wire logic [7:0] residue_addr,
  input wire logic [7:0] residue_data,
  output logic write_latch_flag,
  output logic busy,
  output logic program_erase_fail_flag,
  // array port
  output logic array_prog_we,
  output logic [31:0] array_addr,
  output logic [7:0] array_data,
  output logic array_erase_req,
  output logic [1:0] array_erase_size,
  input wire logic array_fail
);

  typedef enum logic [1:0] {
    IDLE,
    STREAM,
    WAIT_DONE
  } seq_state_type;

  logic [2:0] clk_sync_r;
  logic [1:0] cs_sync_r;
  logic cs_prev_r;
  logic [1:0] si_sync_r;
  logic sck_rise;
  logic cs_rise;
  logic cs_low;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [6:0] shift_r;
  logic byte_done;
  logic [7:0] byte_val;
  logic [7:0] opcode_r;
  logic [31:0] addr_r;
  logic [7:0] buf_ptr_r;
  logic [7:0] buf_mem [0:255];
  logic buf_load_we;
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [7:0] idx_r;
  logic [31:0] timer_r;
  logic is_erase;
  logic is_write_op;
  logic start_op;
  logic abort_op;
  logic irq_armed_r;

  function automatic logic [31:0] erase_base(input logic [31:0] a, input logic [7:0] op);
    logic [31:0] m;
    m = '1;
    unique case (op)
      OP_ERASE_4K: m = '1 << ERASE_LSB_4K;
      OP_ERASE_32K: m = '1 << ERASE_LSB_32K;
      default: m = '1 << ERASE_LSB_64K;
    endcase
    return a & m;
  endfunction

  // second stage only feeds logic; edges compare second and third
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sync_r <= '0;
      cs_sync_r <= '1;
      cs_prev_r <= 1'b1;
      si_sync_r <= '0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], link_clk};
      cs_sync_r <= {cs_sync_r[0], cs_n};
      cs_prev_r <= cs_sync_r[1];
      si_sync_r <= {si_sync_r[0], si};
    end
  end

  assign cs_low = !cs_sync_r[1];
  assign sck_rise = cs_low && clk_sync_r[1] && !clk_sync_r[2];
  assign cs_rise = cs_sync_r[1] && !cs_prev_r;
  assign byte_done = sck_rise && (bit_cnt_r == LAST_BIT);
  assign byte_val = {shift_r, si_sync_r[1]};

  // bit and byte framing; byte count saturates once the header is in
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      shift_r <= '0;
    end else if (!cs_low) begin
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= byte_val[6:0];
      if (byte_done && byte_cnt_r != HDR_BYTES) begin
        byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  // header capture; later bytes never touch the address
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      opcode_r <= '0;
      addr_r <= '0;
    end else if (byte_done && byte_cnt_r == '0) begin
      opcode_r <= byte_val;
    end else if (byte_done && byte_cnt_r < HDR_BYTES) begin
      addr_r <= {addr_r[23:0], byte_val};
    end
  end

  assign is_erase = opcode_r == OP_ERASE_4K || opcode_r == OP_ERASE_32K
                    || opcode_r == OP_ERASE_64K;
  // stale opcode of an earlier frame must not count when no byte came in
  assign is_write_op = (is_erase || opcode_r == OP_BUF_PROGRAM) && byte_cnt_r != '0;
  // op acted on at chip select rise
  // latch gates acceptance; busy devices ignore new program and erase ops
  // full header and byte-aligned release required
  assign start_op = cs_rise && is_write_op && write_latch_flag && state_r == IDLE
                    && byte_cnt_r == HDR_BYTES && bit_cnt_r == '0 && !protected_region;
  assign abort_op = cs_rise && is_write_op && write_latch_flag && state_r == IDLE
                    && !start_op;

  // buffer load pointer wraps naturally at 8 bits
  assign buf_load_we = byte_done && opcode_r == OP_BUF_LOAD && byte_cnt_r == HDR_BYTES;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      buf_ptr_r <= '0;
    end else if (byte_done && byte_cnt_r == HDR_BYTES - 3'h1) begin
      buf_ptr_r <= byte_val;
    end else if (buf_load_we) begin
      buf_ptr_r <= buf_ptr_r + 8'h01;
    end
  end

  // buffer holds load data or residue from byte/page program
  always_ff @(posedge ref_clk) begin
    if (buf_load_we) begin
      buf_mem[buf_ptr_r] <= byte_val;
    end else if (residue_we) begin
      buf_mem[residue_addr] <= residue_data;
    end
  end

  // cleared at start; cleared on abort
  // a set in the same cycle as a clear wins so no enable is lost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_latch_flag <= 1'b0;
    end else if (write_enable_set) begin
      write_latch_flag <= 1'b1;
    end else if (start_op || abort_op) begin
      write_latch_flag <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE: begin
        if (start_op) begin
          state_nxt = is_erase ? WAIT_DONE : STREAM;
        end
      end
      STREAM: begin
        if (idx_r == PAGE_LAST) begin
          state_nxt = WAIT_DONE;
        end
      end
      WAIT_DONE: begin
        if (timer_r == '0) begin
          state_nxt = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // self-timed busy window from start until the timer has expired and any page stream has ended
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_r <= '0;
      busy <= 1'b0;
    end else if (start_op) begin
      timer_r <= is_erase ? 32'(block_erase_cycles - 1) : 32'(page_program_cycles - 1);
      busy <= 1'b1;
    end else begin
      if (timer_r != '0) begin
        timer_r <= timer_r - 32'h1;
      end
      if (state_r == WAIT_DONE && timer_r == '0) begin
        busy <= 1'b0;
      end
    end
  end

  // stream all 256 bytes from offset zero of the page
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idx_r <= '0;
      array_prog_we <= 1'b0;
      array_addr <= '0;
      array_data <= '0;
      array_erase_req <= 1'b0;
      array_erase_size <= ERASE_4K;
    end else begin
      array_prog_we <= state_r == STREAM;
      array_erase_req <= 1'b0;
      if (start_op && is_erase) begin
        // block base with ignored bits masked off
        array_erase_req <= 1'b1;
        array_addr <= erase_base(addr_r, opcode_r);
        array_erase_size <= opcode_r == OP_ERASE_4K ? ERASE_4K :
                            opcode_r == OP_ERASE_32K ? ERASE_32K : ERASE_64K;
      end else if (start_op) begin
        // page index only; dummy bits dropped
        idx_r <= '0;
        array_addr <= {10'h000, addr_r[PAGE_LSB +: PAGE_BITS], 8'h00};
      end else if (state_r == STREAM) begin
        array_addr <= {10'h000, addr_r[PAGE_LSB +: PAGE_BITS], idx_r};
        array_data <= buf_mem[idx_r];
        idx_r <= idx_r + 8'h01;
      end
    end
  end

  // verify failure sticky until next op; set wins over clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      program_erase_fail_flag <= 1'b0;
    end else if (busy && array_fail) begin
      program_erase_fail_flag <= 1'b1;
    end else if (start_op) begin
      program_erase_fail_flag <= 1'b0;
    end
  end

  // status interrupt: after 16 clocks drive busy, low when done
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_armed_r <= 1'b0;
    end else if (!cs_low) begin
      irq_armed_r <= 1'b0;
    end else if (byte_done && byte_cnt_r == IRQ_BYTES - 3'h1
                 && opcode_r == OP_STATUS_IRQ) begin
      irq_armed_r <= 1'b1;
    end
  end

  assign so_oe = irq_armed_r;

  // registered pin; lags busy by one cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      so <= 1'b0;
    end else begin
      so <= irq_armed_r && busy;
    end
  end

endmodule // flash_seq

// ### core/flash_seq_pkg.sv
// constants for the buffer program / block erase sequencer
// assumes a 100 MHz ref_clk and a link clock well below a quarter of it
package flash_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] OP_BUF_LOAD = 8'h84;
  localparam logic [7:0] OP_BUF_PROGRAM = 8'h88;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_STATUS_IRQ = 8'h25;
  // opcode plus four address bytes
  localparam logic [2:0] HDR_BYTES = 3'h5;
  // bytes the host must clock for the status interrupt command (16 clocks)
  localparam logic [2:0] IRQ_BYTES = 3'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // page index sits in address bits 21..8
  localparam int PAGE_LSB = 8;
  localparam int PAGE_BITS = 14;
  localparam int ERASE_LSB_4K = 12;
  localparam int ERASE_LSB_32K = 15;
  localparam int ERASE_LSB_64K = 16;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  // default self-timed durations, shortened in simulation
  localparam int PAGE_PROGRAM_TIME_US = 3000;
  localparam int BLOCK_ERASE_TIME_US = 100000;
  typedef enum logic [1:0] {
    ERASE_4K,
    ERASE_32K,
    ERASE_64K
  } erase_size_type;
endpackage

// ### tb/flash_seq_sva.sv
// port assertions for the program / erase sequencer
// assumes a single ref_clk domain, bound into flash_seq
`timescale 1ns/1ps
module flash_seq_sva #(
  parameter int page_program_cycles = 20,
  parameter int block_erase_cycles = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched pins
  input wire logic so,
  input wire logic so_oe,
  input wire logic write_enable_set,
  input wire logic write_latch_flag,
  input wire logic busy,
  input wire logic program_erase_fail_flag,
  input wire logic array_prog_we,
  input wire logic [31:0] array_addr,
  input wire logic array_erase_req,
  input wire logic [1:0] array_erase_size,
  input wire logic array_fail
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_prog_start;
    array_prog_we && !$past(array_prog_we);
  endsequence
  a_erase_busy: assert property (array_erase_req |->
    busy && write_latch_flag == $past(write_enable_set))
    else $error("erase request without busy or with latch");
  a_prog_busy: assert property (array_prog_we |-> busy)
    else $error("program beat while idle");
  a_page_start: assert property (s_prog_start |-> array_addr[7:0] == 8'h00)
    else $error("page program not at page start");
  a_page_walk: assert property (array_prog_we && $past(array_prog_we) |->
    array_addr[7:0] == $past(array_addr[7:0]) + 8'h01) else $error("page beat skipped");
  a_start_latch: assert property ($rose(busy) |-> $past(write_latch_flag))
    else $error("operation started without latch");
  a_start_clear: assert property ($rose(busy) |->
    write_latch_flag == $past(write_enable_set))
    else $error("latch kept at start");
  a_erase_mask: assert property (array_erase_req |-> array_addr[11:0] == 12'h000 &&
    (array_erase_size == 2'h0 || array_addr[14:12] == 3'h0) &&
    (array_erase_size != 2'h2 || !array_addr[15])) else $error("erase base not aligned");
  a_so_busy: assert property (so_oe && $past(so_oe) |-> so == $past(busy))
    else $error("status output not following busy");
  a_fail_sets: assert property (busy && array_fail |=> program_erase_fail_flag)
    else $error("verify failure not flagged");
endmodule // flash_seq_sva
bind flash_seq flash_seq_sva #(
  .page_program_cycles(page_program_cycles),
  .block_erase_cycles(block_erase_cycles)
) u_sva (.ref_clk(ref_clk), .resetn(resetn), .so(so), .so_oe(so_oe),
  .write_enable_set(write_enable_set),
  .write_latch_flag(write_latch_flag), .busy(busy),
  .program_erase_fail_flag(program_erase_fail_flag), .array_prog_we(array_prog_we),
  .array_addr(array_addr), .array_erase_req(array_erase_req),
  .array_erase_size(array_erase_size), .array_fail(array_fail));

// ### tb/host_model.sv
// host controller model: bit-bangs the link with an 80 ns clock
// assumes the bench starts frames on a ref_clk falling edge
`timescale 1ns/1ps
module host_model (
  // link pins
  output logic link_clk,
  output logic cs_n,
  output logic si
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic xfer(input logic [63:0] d, input int n, input bit keep);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      si = d[63-i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    #40 cs_n = ~keep;
    // released line must not look stable
    si = ~si;
  endtask
endmodule // host_model

// ### tb/tb_flash_seq.sv
// self-checking bench for the program / erase sequencer
// assumes host_model on the link and a recording array port
`timescale 1ns/1ps
module tb_flash_seq;
  import flash_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic write_enable_set = 1'b0;
  logic protected_region = 1'b0;
  logic residue_we = 1'b0;
  logic array_fail = 1'b0;
  logic [7:0] residue_addr = 8'h00;
  logic [7:0] residue_data = 8'h00;
  logic link_clk, cs_n, si, so, so_oe, write_latch_flag, busy, program_erase_fail_flag;
  logic array_prog_we, array_erase_req;
  logic [7:0] array_data;
  logic [31:0] array_addr, er_addr, pg_addr;
  logic [1:0] array_erase_size, er_size;
  logic [7:0] mem [256];
  int n_errors = 0;
  int tests_run = 0;
  int er_n = 0;
  int pg_n = 0;
  always #5 ref_clk = ~ref_clk;
  host_model u_host (.link_clk(link_clk), .cs_n(cs_n), .si(si));
  // long erase time so the status interrupt sees busy
  flash_seq #(.page_program_cycles(20), .block_erase_cycles(400)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .write_enable_set(write_enable_set),
    .protected_region(protected_region), .residue_we(residue_we),
    .residue_addr(residue_addr), .residue_data(residue_data),
    .write_latch_flag(write_latch_flag), .busy(busy),
    .program_erase_fail_flag(program_erase_fail_flag), .array_prog_we(array_prog_we),
    .array_addr(array_addr), .array_data(array_data), .array_erase_req(array_erase_req),
    .array_erase_size(array_erase_size), .array_fail(array_fail));
  always @(posedge ref_clk) begin
    if (array_erase_req) begin
      er_addr <= array_addr;
      er_size <= array_erase_size;
      er_n <= er_n + 1;
    end
    if (array_prog_we) begin
      mem[array_addr[7:0]] <= array_data;
      pg_n <= pg_n + 1;
      if (array_addr[7:0] == 8'h00) pg_addr <= array_addr;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic wen;
    write_enable_set = 1'b1;
    @(negedge ref_clk) write_enable_set = 1'b0;
  endtask
  task automatic settle;
    int i;
    // start is seen a few cycles after chip select rises
    repeat (6) @(negedge ref_clk);
    // poll busy rather than wait worst case
    for (i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    chk("busy end", 0, busy);
  endtask
  task automatic t_erase;
    logic [7:0] op [3] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K};
    logic [31:0] ex [3] = '{32'h00AB_C000, 32'h00AB_8000, 32'h00AB_0000};
    int k;
    for (k = 0; k < 3; k++) begin
      wen();
      u_host.xfer({op[k], 32'h00AB_CDEF, 8'h5C, 16'h0}, 48, 1'b0);
      settle();
      chk("erase addr", ex[k], er_addr);
      chk("erase size", k, er_size);
      chk("erase count", k + 1, er_n);
      chk("erase latch", 0, write_latch_flag);
    end
  endtask
  task automatic t_refuse;
    logic [7:0] op [7] = '{OP_ERASE_4K, OP_ERASE_4K, OP_ERASE_4K, OP_ERASE_64K,
      OP_BUF_PROGRAM, OP_BUF_PROGRAM, OP_BUF_PROGRAM};
    int nb [7] = '{40, 32, 39, 40, 32, 44, 40};
    bit [6:0] pr = 7'b1001000;
    int k, e0, p0;
    e0 = er_n;
    p0 = pg_n;
    for (k = 0; k < 7; k++) begin
      if (k > 0) wen();
      protected_region = pr[k];
      u_host.xfer({op[k], 32'h0000_1000, 24'h0}, nb[k], 1'b0);
      repeat (20) @(negedge ref_clk);
      protected_region = 1'b0;
      chk("refused latch", 0, write_latch_flag);
      chk("refused busy", 0, busy);
    end
    chk("no erase", e0, er_n);
    chk("no program", p0, pg_n);
  endtask
  task automatic t_program;
    residue_addr = 8'h10;
    residue_data = 8'h5A;
    residue_we = 1'b1;
    @(negedge ref_clk) residue_we = 1'b0;
    u_host.xfer({OP_BUF_LOAD, 32'h0000_00FF, 16'hA1B2, 8'h0}, 56, 1'b0);
    repeat (10) @(negedge ref_clk);
    wen();
    u_host.xfer({OP_BUF_PROGRAM, 32'h0012_3456, 24'h0}, 40, 1'b0);
    settle();
    chk("page base", 32'h0012_3400, pg_addr);
    chk("page beats", 256, pg_n);
    chk("end byte", 8'hA1, mem[255]);
    chk("wrap byte", 8'hB2, mem[0]);
    chk("residue byte", 8'h5A, mem[16]);
    chk("program latch", 0, write_latch_flag);
  endtask
  task automatic t_fail;
    wen();
    u_host.xfer({OP_ERASE_4K, 56'h0}, 40, 1'b0);
    repeat (10) @(negedge ref_clk);
    array_fail = 1'b1;
    @(negedge ref_clk) array_fail = 1'b0;
    chk("fail flag", 1, program_erase_fail_flag);
    settle();
  endtask
  task automatic t_irq;
    wen();
    u_host.xfer({OP_ERASE_64K, 56'h0}, 40, 1'b0);
    repeat (8) @(negedge ref_clk);
    chk("fail cleared", 0, program_erase_fail_flag);
    u_host.xfer({OP_STATUS_IRQ, 56'h0}, 16, 1'b1);
    repeat (4) @(negedge ref_clk);
    chk("irq drive", 1, so_oe);
    chk("irq busy", 1, so);
    settle();
    chk("irq done", 0, so);
    u_host.xfer(64'h0, 0, 1'b0);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_erase();
    t_refuse();
    t_program();
    t_fail();
    t_irq();
    tally_and_finish();
  end
  initial begin
    #300_000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_flash_seq
